// ### logic/dgp_pkg.sv
// Constants and carrier types for the dual general-purpose port block.
// Assumes a single core clock and an Avalon-MM register slave.
package dgp_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [4:0] OFF_FIRST_LATCH   = 5'h00;
  localparam logic [4:0] OFF_FIRST_DIR     = 5'h04;
  localparam logic [4:0] OFF_SECOND_LATCH  = 5'h08;
  localparam logic [4:0] OFF_SECOND_DIR    = 5'h0C;
  localparam logic [4:0] OFF_SECOND_PULLUP = 5'h10;
  localparam logic [4:0] OFF_CONFIG        = 5'h14;
  localparam logic [4:0] OFF_STATUS        = 5'h18;

  // Config register fields
  localparam int unsigned CFG_HIZ_BIT = 0;
  localparam int unsigned CFG_RST_BIT = 1;
  // Status register fields
  localparam int unsigned STS_FORCE_BIT = 0;

  // Pin positions inside the register bytes
  localparam int unsigned FIRST_LO  = 0;
  localparam int unsigned FIRST_HI  = 2;
  localparam int unsigned SECOND_LO = 1;
  localparam int unsigned SECOND_HI = 2;

  // Reset values
  localparam logic [2:0] FIRST_RST  = 3'h0;
  localparam logic [1:0] SECOND_RST = 2'h0;
  localparam logic       CFG_HIZ_RST = 1'b0;
  localparam logic       CFG_RST_RST = 1'b0;

  // N-channel open-drain pins and the pin taken by the reset function
  localparam logic [2:0] FIRST_OD_MASK  = 3'h4;
  localparam logic [1:0] SECOND_OD_MASK = 2'h0;
  localparam logic [2:0] RST_PIN_MASK   = 3'h4;

  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [2:0] first;
    logic [1:0] second;
  } dgp_pad_s;
endpackage : dgp_pkg

// ### logic/dgp_port.sv
// Dual general-purpose port: latches, directions, pull-ups, pad control.
// Assumes CPU bus and standby controller run on core_clk; pads are asynchronous.
`timescale 1ns/100ps
`default_nettype none

// Operation
// RULE1 - direction bit one makes pin output
// RULE2 - output pin driven with latch value
// RULE3 - data write updates latch, output follows
// RULE4 - write to input pin stores only
// RULE5 - direction bit zero makes pin input
// RULE6 - read of output pin returns latch
// RULE7 - input read returns pin; RMW returns latch
// RULE8 - reset clears all direction bits
// RULE9 - standby with select forces high impedance
// RULE10 - forced standby blocks input, reads low
// RULE11 - select clear keeps pins in standby
// RULE12 - pull-up bit one connects pull-up
// RULE13 - pull-up off while pin drives low
// RULE14 - open-drain output one is high impedance
// RULE15 - reset select removes third first-port pin
// RULE16 - bits 0..2 first, 1..2 second
// RULE17 - software disables sharing peripheral outputs; no peripheral shares these pads here, so the block has no such control
// RULE18 - unconnected bits read zero, ignore writes
module dgp_port (
  input  wire logic                     core_clk,
  input  wire logic                     rstn,
  input  wire logic [dgp_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [3:0]               avs_byteenable,
  input  wire logic [dgp_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic                     cpu_rmw,
  input  wire logic                     stop_watch_mode,
  input  wire dgp_pkg::dgp_pad_s        pad_in,
  output var  logic [dgp_pkg::DATA_W-1:0] avs_readdata,
  output var  logic                     avs_waitrequest,
  output var  dgp_pkg::dgp_pad_s        pad_out,
  output var  dgp_pkg::dgp_pad_s        pad_oe,
  output var  logic [1:0]               pad_pullup
);

  logic [2:0]              first_port_latch_q;
  logic [2:0]              first_port_dir_q;
  logic [1:0]              second_port_latch_q;
  logic [1:0]              second_port_dir_q;
  logic [1:0]              second_port_pullup_q;
  logic                    standby_pin_hiz_select_q;
  logic                    external_reset_select_q;
  dgp_pkg::dgp_pad_s       sync1_q;
  dgp_pkg::dgp_pad_s       sync2_q;
  logic                    wait_q;
  logic [31:0]             rdata_q;
  logic [31:0]             rdata_d;
  dgp_pkg::dgp_pad_s       oe_d;
  logic [1:0]              pullup_d;
  logic                    force_hiz;
  logic                    wr_go;
  logic                    req;
  logic                    lane0;
  logic [2:0]              first_in;
  logic [1:0]              second_in;
  logic [2:0]              first_rd;
  logic [1:0]              second_rd;

  assign req       = avs_read | avs_write;
  assign wr_go     = avs_write & ~wait_q;
  assign lane0     = avs_byteenable[0];
  assign force_hiz = standby_pin_hiz_select_q & stop_watch_mode; // [RULE9] [RULE11]

  // Bus handshake: one wait cycle then answer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end

  // Latch and direction registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      first_port_latch_q  <= dgp_pkg::FIRST_RST;
      second_port_latch_q <= dgp_pkg::SECOND_RST;
      first_port_dir_q    <= dgp_pkg::FIRST_RST;  // [RULE8]
      second_port_dir_q   <= dgp_pkg::SECOND_RST; // [RULE8]
    end else if (wr_go && lane0) begin
      if (avs_address == dgp_pkg::OFF_FIRST_LATCH) begin
        first_port_latch_q <= avs_writedata[dgp_pkg::FIRST_HI:dgp_pkg::FIRST_LO]; // [RULE3] [RULE4] [RULE16]
      end else if (avs_address == dgp_pkg::OFF_FIRST_DIR) begin
        first_port_dir_q <= avs_writedata[dgp_pkg::FIRST_HI:dgp_pkg::FIRST_LO];
      end else if (avs_address == dgp_pkg::OFF_SECOND_LATCH) begin
        second_port_latch_q <= avs_writedata[dgp_pkg::SECOND_HI:dgp_pkg::SECOND_LO]; // [RULE3] [RULE16] [RULE18]
      end else if (avs_address == dgp_pkg::OFF_SECOND_DIR) begin
        second_port_dir_q <= avs_writedata[dgp_pkg::SECOND_HI:dgp_pkg::SECOND_LO];
      end
    end
  end

  // Pull-up and configuration registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      second_port_pullup_q     <= dgp_pkg::SECOND_RST;
      standby_pin_hiz_select_q <= dgp_pkg::CFG_HIZ_RST;
      external_reset_select_q  <= dgp_pkg::CFG_RST_RST;
    end else if (wr_go && lane0) begin
      if (avs_address == dgp_pkg::OFF_SECOND_PULLUP) begin
        second_port_pullup_q <= avs_writedata[dgp_pkg::SECOND_HI:dgp_pkg::SECOND_LO];
      end else if (avs_address == dgp_pkg::OFF_CONFIG) begin
        standby_pin_hiz_select_q <= avs_writedata[dgp_pkg::CFG_HIZ_BIT];
        external_reset_select_q  <= avs_writedata[dgp_pkg::CFG_RST_BIT];
      end
    end
  end

  // Two-stage pad synchroniser
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pad_in;
      sync2_q <= sync1_q;
    end
  end

  // Input path, blocked low in forced standby or when reset pin
  always_comb begin
    first_in  = sync2_q.first & ~{3{force_hiz}} & ~(dgp_pkg::RST_PIN_MASK & {3{external_reset_select_q}}); // [RULE10] [RULE15]
    second_in = sync2_q.second & ~{2{force_hiz}}; // [RULE10]
    // Latch for outputs or RMW reads, pin otherwise
    first_rd  = cpu_rmw ? first_port_latch_q
              : ((first_port_dir_q & first_port_latch_q) | (~first_port_dir_q & first_in)); // [RULE6] [RULE7]
    second_rd = cpu_rmw ? second_port_latch_q
              : ((second_port_dir_q & second_port_latch_q) | (~second_port_dir_q & second_in)); // [RULE6] [RULE7]
  end

  // Read mux; unmapped and unconnected bits are zero
  always_comb begin
    rdata_d = dgp_pkg::RD_ZERO;
    if (avs_address == dgp_pkg::OFF_FIRST_LATCH) begin
      rdata_d[dgp_pkg::FIRST_HI:dgp_pkg::FIRST_LO] = first_rd;
    end else if (avs_address == dgp_pkg::OFF_FIRST_DIR) begin
      rdata_d[dgp_pkg::FIRST_HI:dgp_pkg::FIRST_LO] = first_port_dir_q;
    end else if (avs_address == dgp_pkg::OFF_SECOND_LATCH) begin
      rdata_d[dgp_pkg::SECOND_HI:dgp_pkg::SECOND_LO] = second_rd; // [RULE18]
    end else if (avs_address == dgp_pkg::OFF_SECOND_DIR) begin
      rdata_d[dgp_pkg::SECOND_HI:dgp_pkg::SECOND_LO] = second_port_dir_q;
    end else if (avs_address == dgp_pkg::OFF_SECOND_PULLUP) begin
      rdata_d[dgp_pkg::SECOND_HI:dgp_pkg::SECOND_LO] = second_port_pullup_q;
    end else if (avs_address == dgp_pkg::OFF_CONFIG) begin
      rdata_d[dgp_pkg::CFG_HIZ_BIT] = standby_pin_hiz_select_q;
      rdata_d[dgp_pkg::CFG_RST_BIT] = external_reset_select_q;
    end else if (avs_address == dgp_pkg::OFF_STATUS) begin
      rdata_d[dgp_pkg::STS_FORCE_BIT] = force_hiz;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= dgp_pkg::RD_ZERO;
    end else if (avs_read && wait_q) begin
      rdata_q <= rdata_d;
    end
  end

  // Pad enables: direction, standby force, open drain, reset pin
  always_comb begin
    oe_d.first  = first_port_dir_q & ~{3{force_hiz}} // [RULE1] [RULE5] [RULE9]
                & ~(dgp_pkg::FIRST_OD_MASK & first_port_latch_q) // [RULE14]
                & ~(dgp_pkg::RST_PIN_MASK & {3{external_reset_select_q}}); // [RULE15]
    oe_d.second = second_port_dir_q & ~{2{force_hiz}} // [RULE1] [RULE5] [RULE9]
                & ~(dgp_pkg::SECOND_OD_MASK & second_port_latch_q); // [RULE14]
    pullup_d    = second_port_pullup_q & ~(oe_d.second & ~second_port_latch_q); // [RULE12] [RULE13]
  end

  // Registered pad outputs
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pad_out    <= '0;
      pad_oe     <= '0;
      pad_pullup <= 2'h0;
    end else begin
      pad_out.first  <= first_port_latch_q; // [RULE2]
      pad_out.second <= second_port_latch_q; // [RULE2]
      pad_oe         <= oe_d;
      pad_pullup     <= pullup_d;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_dir_sets_oe: assert property ( // [RULE1]
    (first_port_dir_q[0] && !force_hiz) |=> pad_oe.first[0])
    else $error("output direction did not enable pad");

  a_input_no_drive: assert property ( // [RULE5]
    !second_port_dir_q[0] |=> !pad_oe.second[0])
    else $error("input pin is driven");

  a_drive_latch: assert property ( // [RULE2]
    pad_oe.first[1] |-> pad_out.first[1] == $past(first_port_latch_q[1]))
    else $error("driven level differs from latch");

  a_write_latch: assert property ( // [RULE3]
    (wr_go && lane0 && avs_address == dgp_pkg::OFF_FIRST_LATCH) |=> ##1
      pad_out.first == $past(avs_writedata[2:0], 2))
    else $error("latch write not seen on pads");

  a_rmw_read: assert property ( // [RULE7]
    (avs_read && wait_q && cpu_rmw && avs_address == dgp_pkg::OFF_SECOND_LATCH) |=>
      !avs_waitrequest && avs_readdata[2:1] == $past(second_port_latch_q))
    else $error("rmw read did not return latch");

  a_standby_hiz: assert property ( // [RULE9]
    force_hiz [*2] |-> pad_oe == '0)
    else $error("pad driven in forced standby");

  a_blocked_input: assert property ( // [RULE10]
    (avs_read && wait_q && force_hiz && !cpu_rmw && avs_address == dgp_pkg::OFF_FIRST_LATCH) |=>
      (avs_readdata[2:0] & ~$past(first_port_dir_q)) == 3'h0)
    else $error("blocked input not read low");

  a_pullup_low: assert property ( // [RULE13]
    (pad_oe.second[1] && !pad_out.second[1]) |-> !pad_pullup[1])
    else $error("pull-up on while driving low");

  a_open_drain: assert property ( // [RULE14]
    first_port_latch_q[2] |=> !pad_oe.first[2])
    else $error("open-drain pin driven high");

  a_reset_pin: assert property ( // [RULE15]
    $past(external_reset_select_q) |-> !pad_oe.first[2])
    else $error("reset pin used as port");

  a_unused_zero: assert property ( // [RULE18]
    !avs_waitrequest |-> avs_readdata[31:3] == 29'h0)
    else $error("unconnected bits read nonzero");

  a_second_dir_oe: assert property ( // [RULE1]
    (second_port_dir_q[1] && !force_hiz) |=> pad_oe.second[1])
    else $error("second port output not enabled");

  a_first_input_idle: assert property ( // [RULE5]
    !first_port_dir_q[0] |=> !pad_oe.first[0])
    else $error("first port input pin is driven");

  a_second_input_idle: assert property ( // [RULE5]
    !second_port_dir_q[1] |=> !pad_oe.second[1])
    else $error("second port input pin is driven");

  a_drive_first0: assert property ( // [RULE2]
    pad_oe.first[0] |-> pad_out.first[0] == $past(first_port_latch_q[0]))
    else $error("first port pin0 level differs from latch");

  a_drive_second: assert property ( // [RULE2]
    (pad_oe.second & (pad_out.second ^ $past(second_port_latch_q))) == 2'h0)
    else $error("second port level differs from latch");

  a_out_follows_latch: assert property ( // [RULE3]
    pad_out.first == $past(first_port_latch_q))
    else $error("first port pads lag the latch");

  a_second_write: assert property ( // [RULE3]
    (wr_go && lane0 && avs_address == dgp_pkg::OFF_SECOND_LATCH) |=>
      second_port_latch_q == $past(avs_writedata[dgp_pkg::SECOND_HI:dgp_pkg::SECOND_LO]))
    else $error("second latch write lost");

  a_latch_any_dir: assert property ( // [RULE4]
    (wr_go && lane0 && avs_address == dgp_pkg::OFF_FIRST_LATCH) |=>
      first_port_latch_q == $past(avs_writedata[dgp_pkg::FIRST_HI:dgp_pkg::FIRST_LO]))
    else $error("first latch write lost");

  a_input_write_quiet: assert property ( // [RULE4]
    (wr_go && lane0 && avs_address == dgp_pkg::OFF_FIRST_LATCH && first_port_dir_q == 3'h0) |=> ##1
      pad_oe.first == 3'h0)
    else $error("latch write drove an input pin");

  a_read_output: assert property ( // [RULE6]
    (avs_read && wait_q && !cpu_rmw && first_port_dir_q == '1 &&
      avs_address == dgp_pkg::OFF_FIRST_LATCH) |=> avs_readdata[2:0] == $past(first_port_latch_q))
    else $error("output pin read did not return latch");

  a_rmw_first: assert property ( // [RULE7]
    (avs_read && wait_q && cpu_rmw && avs_address == dgp_pkg::OFF_FIRST_LATCH) |=>
      avs_readdata[2:0] == $past(first_port_latch_q))
    else $error("rmw read of first port did not return latch");

  a_read_pin: assert property ( // [RULE7]
    (avs_read && wait_q && !cpu_rmw && !force_hiz && !external_reset_select_q &&
      first_port_dir_q == 3'h0 && avs_address == dgp_pkg::OFF_FIRST_LATCH) |=>
      avs_readdata[2:0] == $past(sync2_q.first))
    else $error("input read did not return pin level");

  a_blocked_second: assert property ( // [RULE10]
    (avs_read && wait_q && force_hiz && !cpu_rmw && avs_address == dgp_pkg::OFF_SECOND_LATCH) |=>
      (avs_readdata[2:1] & ~$past(second_port_dir_q)) == 2'h0)
    else $error("blocked second port input not read low");

  a_select_clear_keeps: assert property ( // [RULE11]
    (!standby_pin_hiz_select_q && stop_watch_mode) |=> pad_oe.second == $past(second_port_dir_q))
    else $error("standby changed pins with select clear");

  a_status_force: assert property ( // [RULE9]
    (avs_read && wait_q && avs_address == dgp_pkg::OFF_STATUS) |=>
      avs_readdata[dgp_pkg::STS_FORCE_BIT] == $past(force_hiz))
    else $error("status does not show forced standby");

  a_pullup_on: assert property ( // [RULE12]
    (second_port_pullup_q[0] && !second_port_dir_q[0]) |=> pad_pullup[0])
    else $error("enabled pull-up not connected");

  a_pullup_off: assert property ( // [RULE12]
    !second_port_pullup_q[1] |=> !pad_pullup[1])
    else $error("disabled pull-up connected");

  a_pullup_low0: assert property ( // [RULE13]
    (pad_oe.second[0] && !pad_out.second[0]) |-> !pad_pullup[0])
    else $error("pin1 pull-up on while driving low");

  a_open_drain_low: assert property ( // [RULE14]
    (first_port_dir_q[2] && !first_port_latch_q[2] && !force_hiz && !external_reset_select_q) |=>
      pad_oe.first[2])
    else $error("open-drain pin not pulling low");

  a_reset_pin_read: assert property ( // [RULE15]
    (avs_read && wait_q && !cpu_rmw && external_reset_select_q && !first_port_dir_q[2] &&
      avs_address == dgp_pkg::OFF_FIRST_LATCH) |=> !avs_readdata[2])
    else $error("reset pin read as port");

  a_map_second: assert property ( // [RULE16]
    (avs_read && wait_q && avs_address == dgp_pkg::OFF_SECOND_DIR) |=>
      avs_readdata[2:1] == $past(second_port_dir_q))
    else $error("second port direction bits misplaced");

  a_second_bit0: assert property ( // [RULE18]
    (avs_read && wait_q && avs_address == dgp_pkg::OFF_SECOND_LATCH) |=> !avs_readdata[0])
    else $error("second port bit0 read nonzero");

  a_lane_ignored: assert property ( // [RULE18]
    (avs_write && !wait_q && !lane0) |=> $stable(first_port_latch_q))
    else $error("write without lane0 changed latch");

  a_one_wait: assert property ( // [RULE3]
    (req && wait_q) |=> !avs_waitrequest)
    else $error("request not answered after one wait");

  a_wait_single: assert property ( // [RULE3]
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for two cycles");

endmodule // dgp_port

`default_nettype wire

// ### verification/dgp_pin_model.sv
// Board-side model of the five port pads.
// Assumes the bench sets the far-side level of every pad that no one drives.
`timescale 1ns/100ps
`default_nettype none
module dgp_pin_model (
  input  wire logic              [1:0] pad_pullup,
  input  wire dgp_pkg::dgp_pad_s       pad_out,
  input  wire dgp_pkg::dgp_pad_s       pad_oe,
  input  wire dgp_pkg::dgp_pad_s       ext_level,
  output var  dgp_pkg::dgp_pad_s       pad_level
);
  // No peripheral shares the pads here, so only the port drives them
  // Driven pad shows the port; released pad is pulled up or follows the board
  assign pad_level = (pad_oe & pad_out) | (~pad_oe & (5'({3'h0, pad_pullup}) | ext_level));
endmodule // dgp_pin_model
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the dual port block over Avalon-MM.
// Assumes dgp_pin_model closes the pad loop.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic              core_clk, rstn, rd, wr, rmw, swm;
  logic [4:0]        addr;
  logic [3:0]        be;
  logic [31:0]       wdata, rdata, got;
  logic              wreq;
  logic [1:0]        pup;
  dgp_pkg::dgp_pad_s pout, poe, plevel, ext;
  int                fails, comparisons, cycles;

  dgp_port dut (.core_clk(core_clk), .rstn(rstn), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_byteenable(be), .avs_writedata(wdata), .cpu_rmw(rmw), .stop_watch_mode(swm), .pad_in(plevel),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .pad_out(pout), .pad_oe(poe), .pad_pullup(pup));
  dgp_pin_model pins (.pad_pullup(pup), .pad_out(pout), .pad_oe(poe), .ext_level(ext), .pad_level(plevel));

  always #2 core_clk = ~core_clk;

  task automatic end_sim;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Ceiling well above the roughly 130 cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One bus cycle, held until waitrequest is seen low
  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d, input logic m);
    addr <= a;
    wdata <= {24'h0, d};
    wr <= w;
    rd <= ~w;
    rmw <= m;
    @(posedge core_clk);
    while (wreq !== 1'b0) @(posedge core_clk);
    got = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    rmw <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wrr(input logic [4:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 1'b0);
  endtask

  task automatic rdc(input logic [4:0] a, input logic m, input logic [7:0] e);
    xfer(1'b0, a, 8'h00, m);
    chk(got, {24'h0, e});
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  initial begin
    core_clk = 1'b0; rstn = 1'b0; rd = 1'b0; wr = 1'b0; rmw = 1'b0; swm = 1'b0;
    addr = 5'h00; be = 4'hF; wdata = 32'h0; ext = 5'h00;
    step(10);
    rstn <= 1'b1;
    step(1);
    chk({27'h0, poe}, 32'h0);
    rdc(dgp_pkg::OFF_FIRST_DIR, 1'b0, 8'h00);
    rdc(dgp_pkg::OFF_SECOND_DIR, 1'b0, 8'h00);
    $display("test reset done");
    wrr(dgp_pkg::OFF_FIRST_LATCH, 8'h03);
    wrr(dgp_pkg::OFF_FIRST_DIR, 8'hFF);
    step(1);
    chk({27'h0, poe}, 32'h1C);
    chk({27'h0, pout}, 32'h0C);
    rdc(dgp_pkg::OFF_FIRST_LATCH, 1'b0, 8'h03);
    wrr(dgp_pkg::OFF_FIRST_LATCH, 8'h07);
    step(1);
    chk({27'h0, poe}, 32'h0C);
    rdc(dgp_pkg::OFF_FIRST_DIR, 1'b0, 8'h07);
    be <= 4'h0;
    wrr(dgp_pkg::OFF_FIRST_LATCH, 8'h00);
    be <= 4'hF;
    rdc(dgp_pkg::OFF_FIRST_LATCH, 1'b0, 8'h07);
    $display("test output done");
    wrr(dgp_pkg::OFF_FIRST_DIR, 8'h00);
    wrr(dgp_pkg::OFF_FIRST_LATCH, 8'h05);
    ext <= 5'h18;
    step(3);
    chk({27'h0, poe}, 32'h00);
    rdc(dgp_pkg::OFF_FIRST_LATCH, 1'b0, 8'h06);
    rdc(dgp_pkg::OFF_FIRST_LATCH, 1'b1, 8'h05);
    $display("test input done");
    wrr(dgp_pkg::OFF_SECOND_LATCH, 8'hFF);
    rdc(dgp_pkg::OFF_SECOND_LATCH, 1'b1, 8'h06);
    wrr(dgp_pkg::OFF_SECOND_LATCH, 8'h02);
    wrr(dgp_pkg::OFF_SECOND_DIR, 8'h06);
    wrr(dgp_pkg::OFF_SECOND_PULLUP, 8'h06);
    step(1);
    chk({27'h0, pout}, 32'h15);
    chk({30'h0, pup}, 32'h01);
    wrr(dgp_pkg::OFF_SECOND_DIR, 8'h00);
    ext <= 5'h00;
    step(3);
    chk({30'h0, pup}, 32'h03);
    rdc(dgp_pkg::OFF_SECOND_LATCH, 1'b0, 8'h06);
    $display("test second port done");
    wrr(dgp_pkg::OFF_FIRST_DIR, 8'h03);
    wrr(dgp_pkg::OFF_SECOND_DIR, 8'h06);
    wrr(dgp_pkg::OFF_CONFIG, 8'h01);
    ext <= 5'h1F;
    swm <= 1'b1;
    step(3);
    chk({27'h0, poe}, 32'h00);
    rdc(dgp_pkg::OFF_SECOND_LATCH, 1'b0, 8'h02);
    rdc(dgp_pkg::OFF_FIRST_LATCH, 1'b0, 8'h01);
    rdc(dgp_pkg::OFF_STATUS, 1'b0, 8'h01);
    swm <= 1'b0;
    wrr(dgp_pkg::OFF_CONFIG, 8'h00);
    swm <= 1'b1;
    step(2);
    chk({27'h0, poe}, 32'h0F);
    swm <= 1'b0;
    $display("test standby done");
    wrr(dgp_pkg::OFF_CONFIG, 8'h02);
    wrr(dgp_pkg::OFF_FIRST_DIR, 8'h07);
    wrr(dgp_pkg::OFF_FIRST_LATCH, 8'h00);
    step(1);
    chk({27'h0, poe}, 32'h0F);
    wrr(dgp_pkg::OFF_FIRST_DIR, 8'h00);
    step(3);
    rdc(dgp_pkg::OFF_FIRST_LATCH, 1'b0, 8'h03);
    wrr(5'h1C, 8'hFF);
    rdc(5'h1C, 1'b0, 8'h00);
    $display("test reset pin and unmapped done");
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
